/* rtl/usb_dma_teardown_completion.sv */
// usb endpoint dma: rx error status handling, tx copy into fifo, teardown
// assumes software keeps the quiesce sequence; all pins synchronous to clk_sys
//
// Behaviour
// - teardown on active endpoint may hang
// - iso rx dma clears pid/crc errors
// - error interrupt may show zero cause bits
// - tx completion fires when the last word is in the fifo
// - wire errors may follow tx completion
`timescale 1ns/1ps
module usb_dma_teardown_completion #(
    parameter int DEPTH = usb_dma_pkg::FIFO_DEPTH,
    parameter int QUIESCE = usb_dma_pkg::QUIESCE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // rx side
    input wire logic rxDmaEnableBit,
    input wire logic rxIsoMode,
    input wire logic rxPacketDone,
    input wire logic rxPidError,
    input wire logic rxCrcError,
    input wire logic rxStatusRead,
    output logic rxPidErrorStatus,
    output logic rxCrcErrorStatus,
    output logic rxErrorIrq,
    // teardown
    input wire logic teardownReq,
    output logic teardownDone,
    output logic teardownHang,
    // tx copy from memory
    input wire logic txStart,
    input wire logic [usb_dma_pkg::CNT_W-1:0] txLength,
    input wire logic [usb_dma_pkg::DATA_W-1:0] txMemData,
    output logic txMemReq,
    output logic txCompleteIrq,
    // usb wire side
    output logic [usb_dma_pkg::DATA_W-1:0] wireData,
    output logic wireValid,
    input wire logic wireReady,
    input wire logic wireNakTimeout,
    output logic txErrorIrq,
    output logic txFifoEmpty
);
    import usb_dma_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic pidErr;
        logic crcErr;
        logic errIrq;
        logic [CNT_W-1:0] quiesceCnt;
        logic tdDone;
        logic tdHang;
        txState_e txState;
        logic [CNT_W-1:0] remain;
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
        logic txIrq;
        logic txErr;
    } state_s;

    state_s state_reg, state_next;
    logic [DATA_W-1:0] fifoMem [DEPTH];
    logic fifoFull, fifoEmpty, pushNow, popNow;

    function automatic logic [AW:0] ptrInc(input logic [AW:0] p);
        ptrInc = p + {{AW{1'b0}}, 1'b1};
    endfunction

    // fifo flags from pointer difference
    assign fifoEmpty = (state_reg.wrPtr == state_reg.rdPtr);
    assign fifoFull = (state_reg.wrPtr[AW] != state_reg.rdPtr[AW]) &&
                      (state_reg.wrPtr[AW-1:0] == state_reg.rdPtr[AW-1:0]);
    assign pushNow = (state_reg.txState == TX_COPY) && !fifoFull && (state_reg.remain != CNT_ZERO);
    assign popNow = !fifoEmpty && wireReady;

    // next-state logic for the whole block
    always_comb begin
        state_next = state_reg;
        state_next.errIrq = 1'b0;
        state_next.txIrq = 1'b0;
        state_next.txErr = 1'b0;
        state_next.tdDone = 1'b0;
        // iso clears status
        // errors latch from the wire; set wins over a cpu read clear
        if (rxStatusRead) begin
            state_next.pidErr = 1'b0;
            state_next.crcErr = 1'b0;
        end
        if (rxIsoMode && rxPacketDone && rxDmaEnableBit) begin
            state_next.pidErr = 1'b0;
            state_next.crcErr = 1'b0;
        end
        if (rxPidError) begin
            state_next.pidErr = 1'b1;
        end
        if (rxCrcError) begin
            state_next.crcErr = 1'b1;
        end
        // interrupt fires anyway
        // the pulse is raised from the event, not from the held status bits
        if (rxPidError || rxCrcError) begin
            state_next.errIrq = 1'b1;
        end
        // quiesce tracking
        // counts cycles since rx dma was disabled; teardown before that may hang
        if (rxDmaEnableBit) begin
            state_next.quiesceCnt = CNT_ZERO;
        end else if (state_reg.quiesceCnt < QUIESCE[CNT_W-1:0]) begin
            state_next.quiesceCnt = state_reg.quiesceCnt + CNT_ONE;
        end
        // tx copy engine
        if (pushNow) begin
            state_next.wrPtr = ptrInc(state_reg.wrPtr);
            state_next.remain = state_reg.remain - CNT_ONE;
        end
        if (popNow) begin
            state_next.rdPtr = ptrInc(state_reg.rdPtr);
        end
        // teardown comes after push and pop so that its flush wins over a word taken in the same cycle
        if (teardownReq && !state_reg.tdHang) begin
            if (rxDmaEnableBit || state_reg.quiesceCnt < QUIESCE[CNT_W-1:0]) begin
                state_next.tdHang = 1'b1; // stuck until reset, as the silicon does
            end else begin
                state_next.tdDone = 1'b1;
                state_next.wrPtr = state_next.rdPtr;
                state_next.remain = CNT_ZERO;
                state_next.txState = TX_IDLE;
            end
        end
        if (wireNakTimeout && state_reg.txState == TX_DRAIN) begin
            state_next.txErr = 1'b1;
        end
        if (!state_reg.tdHang && !(teardownReq && state_next.tdDone)) begin
            case (state_reg.txState)
                TX_IDLE: begin
                    if (txStart && txLength != CNT_ZERO) begin
                        state_next.remain = txLength;
                        state_next.txState = TX_COPY;
                    end
                end
                TX_COPY: begin
                    // early completion
                    // completion raised once the last word is in the fifo
                    if (pushNow && state_reg.remain == CNT_ONE) begin
                        state_next.txIrq = 1'b1;
                        state_next.txState = TX_DRAIN;
                    end
                end
                TX_DRAIN: begin
                    if (fifoEmpty) begin
                        state_next.txState = TD_DONE;
                    end
                end
                TD_DONE: begin
                    state_next.txState = TX_IDLE;
                end
                default: begin
                    state_next.txState = TX_IDLE;
                end
            endcase
        end
        if (state_reg.tdHang) begin
            state_next.txState = state_reg.txState; // hung engine keeps its tx state; fifo pushes and pops still go on
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= '{pidErr: 1'b0, crcErr: 1'b0, errIrq: 1'b0, quiesceCnt: CNT_ZERO, tdDone: 1'b0,
                           tdHang: 1'b0, txState: TX_IDLE, remain: CNT_ZERO, wrPtr: '0, rdPtr: '0,
                           txIrq: 1'b0, txErr: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // fifo storage has no reset; reads are guarded by the empty flag
    always_ff @(posedge clk_sys) begin
        if (pushNow) begin
            fifoMem[state_reg.wrPtr[AW-1:0]] <= txMemData;
        end
    end

    // outputs
    assign rxPidErrorStatus = state_reg.pidErr;
    assign rxCrcErrorStatus = state_reg.crcErr;
    assign rxErrorIrq = state_reg.errIrq;
    assign teardownDone = state_reg.tdDone;
    assign teardownHang = state_reg.tdHang;
    assign txMemReq = pushNow;
    assign txCompleteIrq = state_reg.txIrq;
    assign txErrorIrq = state_reg.txErr;
    assign wireValid = !fifoEmpty;
    assign wireData = fifoMem[state_reg.rdPtr[AW-1:0]];
    // empty after wire
    // empty only when nothing is being copied and the fifo has drained to the wire
    assign txFifoEmpty = fifoEmpty && (state_reg.txState != TX_COPY);

    sequence lastPush_s;
        pushNow && state_reg.remain == CNT_ONE && state_reg.txState == TX_COPY && !state_reg.tdHang;
    endsequence
    sequence irqNext_s;
        ##1 txCompleteIrq;
    endsequence
    property earlyDone_p;
        @(posedge clk_sys) disable iff (sys_rst) lastPush_s |-> irqNext_s;
    endproperty
    tx_early_done_a: assert property (earlyDone_p) else $error("tx completion not raised after last copy");

    tx_empty_status_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        txFifoEmpty |-> !wireValid && state_reg.txState != TX_COPY) else $error("fifo empty with data left");

    irq_before_empty_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        txCompleteIrq |-> !txFifoEmpty) else $error("completion came after the wire drained");

    iso_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rxIsoMode && rxPacketDone && rxDmaEnableBit && !rxPidError && !rxCrcError |=> !rxPidErrorStatus
        && !rxCrcErrorStatus) else $error("iso errors not cleared by dma");

    err_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rxPidError || rxCrcError) |=> rxErrorIrq) else $error("error interrupt missing");

    td_hang_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        teardownReq && rxDmaEnableBit && !teardownHang |=> teardownHang && !teardownDone)
        else $error("teardown on active endpoint did not hang");

    late_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wireNakTimeout && state_reg.txState == TX_DRAIN |=> txErrorIrq) else $error("late wire error lost");
endmodule // usb_dma_teardown_completion

/* rtl/usb_dma_pkg.sv */
// package for the usb endpoint dma block: states, widths, timing constants
// assumes a single 40 MHz system clock
package usb_dma_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int QUIESCE_US = 250;
    // least time in whole cycles: 250 us at 40 cycles per us
    localparam int QUIESCE_CYCLES = (QUIESCE_US * (CLK_HZ / 1000000) + 0) ;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_COPY = 4'h2,
        TX_DRAIN = 4'h4,
        TD_DONE = 4'h8
    } txState_e;
endpackage

/* bench/usb_wire_sink.sv */
// wire-side partner: takes fifo words with random stalls and reports each word
// assumes all signals are synchronous to clk_sys
`timescale 1ns/1ps
module usb_wire_sink (
    input wire logic clk_sys,
    input wire logic [usb_dma_pkg::DATA_W-1:0] wireData,
    input wire logic wireValid,
    output logic wireReady,
    output logic gotStb,
    output logic [usb_dma_pkg::DATA_W-1:0] gotData
);
    import usb_dma_pkg::*;
    int seed = 32'h441a0e3a;
    initial wireReady = 1'b0;
    initial gotStb = 1'b0;
    initial gotData = '0;
    // random ready, so the drain stalls and the completion flag races ahead
    always @(posedge clk_sys) begin
        gotStb <= wireValid && wireReady;
        gotData <= wireData;
        wireReady <= ($random(seed) % 3) != 0;
    end
endmodule // usb_wire_sink

/* bench/usb_dma_teardown_completion_tb.sv */
// self-checking bench for the usb endpoint dma block
// assumes the wire sink partner; quiesce shortened to 20 cycles
`timescale 1ns/1ps
module usb_dma_teardown_completion_tb;
    import usb_dma_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic rxDmaEnableBit = 0, rxIsoMode = 0, rxPacketDone = 0, rxPidError = 0, rxCrcError = 0, rxStatusRead = 0;
    logic teardownReq = 0, txStart = 0, wireNakTimeout = 0, wireReady, gotStb;
    logic [CNT_W-1:0] txLength = '0;
    logic [DATA_W-1:0] txMemData = '0, wireData, gotData;
    logic rxPidErrorStatus, rxCrcErrorStatus, rxErrorIrq, teardownDone, teardownHang;
    logic txMemReq, txCompleteIrq, wireValid, txErrorIrq, txFifoEmpty;
    logic [DATA_W-1:0] expQ[$];
    int seed = 32'h441a0e3a;
    int n_fail = 0, tests_run = 0, cycles = 0;
    usb_dma_teardown_completion #(.DEPTH(FIFO_DEPTH), .QUIESCE(20)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .rxDmaEnableBit(rxDmaEnableBit), .rxIsoMode(rxIsoMode), .rxPacketDone(rxPacketDone),
        .rxPidError(rxPidError), .rxCrcError(rxCrcError), .rxStatusRead(rxStatusRead),
        .rxPidErrorStatus(rxPidErrorStatus), .rxCrcErrorStatus(rxCrcErrorStatus), .rxErrorIrq(rxErrorIrq),
        .teardownReq(teardownReq), .teardownDone(teardownDone), .teardownHang(teardownHang),
        .txStart(txStart), .txLength(txLength), .txMemData(txMemData), .txMemReq(txMemReq),
        .txCompleteIrq(txCompleteIrq), .wireData(wireData), .wireValid(wireValid), .wireReady(wireReady),
        .wireNakTimeout(wireNakTimeout), .txErrorIrq(txErrorIrq), .txFifoEmpty(txFifoEmpty));
    usb_wire_sink i_sink (.clk_sys(clk_sys), .wireData(wireData), .wireValid(wireValid),
        .wireReady(wireReady), .gotStb(gotStb), .gotData(gotData));
    always #12.5 clk_sys = ~clk_sys;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // note each word taken from memory, compare each word seen on the wire in fifo order
    always @(posedge clk_sys) begin
        cycles++;
        if (txMemReq) expQ.push_back(txMemData);
        txMemData <= $random(seed);
        if (gotStb) check(gotData, expQ.size() ? expQ.pop_front() : ~gotData);
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // one copy, a nak while draining, then wait for the empty flag
    task automatic tx_run(input int len);
        int n;
        @(posedge clk_sys) txStart <= 1'b1;
        txLength <= len[CNT_W-1:0];
        @(posedge clk_sys) txStart <= 1'b0;
        for (n = 0; n < 200 && txCompleteIrq !== 1'b1; n++) @(negedge clk_sys);
        check(txCompleteIrq, 1);
        check(txFifoEmpty, 0);
        @(posedge clk_sys) wireNakTimeout <= 1'b1;
        @(posedge clk_sys) wireNakTimeout <= 1'b0;
        @(negedge clk_sys);
        check(txErrorIrq, 1);
        for (n = 0; n < 400 && txFifoEmpty !== 1'b1; n++) @(negedge clk_sys);
        @(negedge clk_sys);
        check(expQ.size(), 0);
        $display("test tx len %0d done", len);
    endtask
    initial begin
        int k;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        tx_run(5);
        tx_run(FIFO_DEPTH);
        // every error kind in iso and plain mode; iso packet end wipes the status
        @(posedge clk_sys) rxDmaEnableBit <= 1'b1;
        for (k = 0; k < 4; k++) begin
            @(posedge clk_sys) rxIsoMode <= k[1];
            rxPidError <= !k[0];
            rxCrcError <= k[0];
            @(posedge clk_sys) rxPidError <= 1'b0;
            rxCrcError <= 1'b0;
            @(negedge clk_sys);
            check(rxErrorIrq, 1);
            check({rxPidErrorStatus, rxCrcErrorStatus}, k[0] ? 2'b01 : 2'b10);
            @(posedge clk_sys) rxPacketDone <= 1'b1;
            @(posedge clk_sys) rxPacketDone <= 1'b0;
            @(negedge clk_sys);
            // in iso mode the interrupt came but its cause now reads zero, so software drops it
            check(rxPidErrorStatus | rxCrcErrorStatus, !k[1]);
            @(posedge clk_sys) rxStatusRead <= 1'b1;
            @(posedge clk_sys) rxStatusRead <= 1'b0;
        end
        $display("test rx status done");
        // teardown while the endpoint is still active
        @(posedge clk_sys) teardownReq <= 1'b1;
        @(posedge clk_sys) teardownReq <= 1'b0;
        @(negedge clk_sys);
        check({teardownHang, teardownDone}, 2'b10);
        @(posedge clk_sys) sys_rst <= 1'b1;
        @(posedge clk_sys) sys_rst <= 1'b0;
        // disable rx dma and wait out the quiesce time
        rxDmaEnableBit <= 1'b0;
        repeat (22) @(posedge clk_sys);
        teardownReq <= 1'b1;
        @(posedge clk_sys) teardownReq <= 1'b0;
        @(negedge clk_sys);
        check({teardownHang, teardownDone}, 2'b01);
        $display("test teardown done");
        summarize();
    end
endmodule // usb_dma_teardown_completion_tb
